// file: verilog/siqs_sequencer.sv
`timescale 1ns/1ps
// What this block does
// R1: answer only A24 cycles with modifier 39,3A,3B,3D,3E,3F.
// R2: select when A23..A16 equal the two nibble switches.
// R3: byte, aligned word, long, read-modify-write and block long transfers.
// R4: indicators for completed access and for a valid modifier.
// R5: tone mode leaves carriers unmodulated; main channels use sweep memory.
// R6: controller must give at least one step strobe first.
// R7: quadrature mode: each channel own modulation memory and length.
// R8: single frequency uses only the idle sweep word.
// R9: one sweep word read per strobe, pointer advanced after.
// R10: sweep memory 2048 by 32 bits, most significant byte first.
// R11: software must load a valid idle frequency word.
// R12: at sweep end jump to idle or hold, per end control.
// R13: zero sweep length keeps pointer on idle word.
// R14: modulation memory 2048 I,Q pairs of 10 bits, I first.
// R15: inactive gate forces the modulation pointer to first pair.
// R16: past its length the pointer goes idle or holds, per control.
// R17: zero modulation length keeps pointer on idle pair.
// R18: pointer steps after buffer-factor count of 20 MHz samples.
// R19: modulation values are signed two's complement.
// R20: trip event latched, disables summed output until cleared.
// R21: active gate enables channel output and, in quadrature, modulation.
// R22: buffer factor is 12 bits, step delay is factor times 50 ns, factor 0 acting as 1.
// R23: strobe and gates synchronised, each strobe edge acted on once; an edge while one is pending merges into it.
module siqs_sequencer (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_VME_AS_N,
  input wire logic [1:0] I_VME_DS_N,
  input wire logic I_VME_LWORD_N,
  input wire logic I_VME_WRITE_N,
  input wire logic [5:0] I_VME_AM,
  input wire logic [23:1] I_VME_ADDR,
  input wire logic [31:0] I_VME_DATA,
  output logic [31:0] O_VME_DATA,
  output logic O_VME_DATA_OE,
  output logic O_VME_DTACK_N,
  output logic O_VME_DTACK_OE,
  input wire logic [3:0] I_LOW_NIBBLE_SWITCH,
  input wire logic [3:0] I_HIGH_NIBBLE_SWITCH,
  output logic O_ACCESS_INDICATOR,
  output logic O_MODIFIER_VALID_INDICATOR,
  input wire logic I_QUAD_MODE,
  input wire logic I_SINGLE_FREQ,
  input wire logic [5:0] I_END_SWEEP_CTRL,
  input wire logic [10:0] I_SWEEP_LEN,
  input wire logic I_SWEEP_ADDR_RESET,
  input wire logic I_SWEEP_STEP_STROBE,
  input wire logic [4:0] I_CHAN_GATE,
  input wire logic [4:0][10:0] I_IQ_LEN,
  input wire logic [4:0][11:0] I_BUFFER_FACTOR,
  input wire logic I_POWER_TRIP_INPUT,
  input wire logic I_TRIP_CLEAR,
  output logic O_FREQ_VALID,
  output logic [31:0] O_FREQ_WORD,
  input wire logic I_FREQ_READY,
  output logic [10:0] O_SWEEP_ADDR,
  output logic O_SWEEP_AT_IDLE,
  output siqs_pkg::siqs_iq_s [4:0] O_IQ,
  output logic [4:0][10:0] O_IQ_ADDR,
  output logic [4:0] O_MOD_ENABLE,
  output logic [4:0] O_CHAN_RF_ENABLE,
  output logic O_RF_ENABLE,
  output logic O_TRIP_STATUS
);
  function automatic logic am_ok(input logic [5:0] am);
    am_ok = (am == siqs_pkg::AM_USR_DATA) || (am == siqs_pkg::AM_USR_PROG)
         || (am == siqs_pkg::AM_USR_BLT) || (am == siqs_pkg::AM_SUP_DATA)
         || (am == siqs_pkg::AM_SUP_PROG) || (am == siqs_pkg::AM_SUP_BLT);
  endfunction : am_ok

  function automatic logic [3:0] lanes(input logic half,
                                       input logic [1:0] ds_n,
                                       input logic lword_n);
    if (!lword_n) begin
      lanes = 4'hf;
    end else if (half) begin
      lanes = {2'h0, ~ds_n};
    end else begin
      lanes = {~ds_n, 2'h0};
    end
  endfunction : lanes

  // shared by the sweep and all modulation pointers
  function automatic logic [10:0] step_ptr(input logic [10:0] p,
                                           input logic [10:0] len,
                                           input logic to_idle);
    if (len == siqs_pkg::LEN_ZERO || p == siqs_pkg::IDX_IDLE) begin
      step_ptr = siqs_pkg::IDX_IDLE;
    end else if (p == len - siqs_pkg::ONE_IDX) begin
      step_ptr = to_idle ? siqs_pkg::IDX_IDLE : p;
    end else begin
      step_ptr = p + siqs_pkg::ONE_IDX;
    end
  endfunction : step_ptr

  siqs_pkg::siqs_state_e st_reg, st_next;
  siqs_pkg::siqs_beat_s beat_reg;
  logic as_low_reg;
  logic [23:1] addr_reg;
  logic [5:0] am_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rd_word;
  logic [31:0] sweep_rd_a, sweep_rd_b;
  logic [19:0] iq_rd_a [siqs_pkg::NCH];
  logic [19:0] iq_rd_b [siqs_pkg::NCH];
  logic [3:0] sweep_we;
  logic [10:0] sweep_rd_idx;
  logic [2:0] rgn;
  logic selected, ds_any, ds_none, is_blt;

  assign rgn = addr_reg[15:13];
  assign selected = am_ok(am_reg)  // [R1]
    && addr_reg[23:16] == {I_HIGH_NIBBLE_SWITCH, I_LOW_NIBBLE_SWITCH}; // [R2]
  assign ds_any = !(&I_VME_DS_N);
  assign ds_none = &I_VME_DS_N;
  assign is_blt = am_reg == siqs_pkg::AM_USR_BLT
               || am_reg == siqs_pkg::AM_SUP_BLT;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      siqs_pkg::ST_IDLE: begin
        if (as_low_reg && ds_any && selected) begin
          st_next = siqs_pkg::ST_SEL;
        end
      end
      siqs_pkg::ST_SEL: st_next = siqs_pkg::ST_FETCH;
      siqs_pkg::ST_FETCH: st_next = siqs_pkg::ST_ACK;
      // rmw and block beats come back through idle on the next strobe
      siqs_pkg::ST_ACK: begin
        if (ds_none) begin
          st_next = siqs_pkg::ST_IDLE;
        end
      end
      default: st_next = siqs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      st_reg <= siqs_pkg::ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      as_low_reg <= 1'b0;
      addr_reg <= 23'h000000;
      am_reg <= 6'h00;
    end else begin
      as_low_reg <= !I_VME_AS_N;
      if (!as_low_reg && !I_VME_AS_N) begin
        addr_reg <= I_VME_ADDR;
        am_reg <= I_VME_AM;
      end else if (st_reg == siqs_pkg::ST_ACK && ds_none && is_blt) begin
        addr_reg <= addr_reg + siqs_pkg::BLT_STEP; // [R3]
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      beat_reg <= '0;
      wdata_reg <= 32'h00000000;
    end else if (st_reg == siqs_pkg::ST_IDLE
                 && st_next == siqs_pkg::ST_SEL) begin
      beat_reg.be <= lanes(addr_reg[1], I_VME_DS_N, I_VME_LWORD_N); // [R3]
      beat_reg.wr <= !I_VME_WRITE_N;
      beat_reg.lword <= !I_VME_LWORD_N;
      beat_reg.half <= addr_reg[1];
      // short data rides on D15..D0, copy it to both word halves
      wdata_reg <= I_VME_LWORD_N ? {I_VME_DATA[15:0], I_VME_DATA[15:0]}
                                 : I_VME_DATA;
    end
  end

  assign sweep_we = (st_reg == siqs_pkg::ST_SEL && beat_reg.wr
                     && rgn == siqs_pkg::RGN_SWEEP) ? beat_reg.be : 4'h0;

  always_comb begin
    rd_word = 32'h00000000;
    if (rgn == siqs_pkg::RGN_SWEEP) begin
      rd_word = sweep_rd_a;
    end else if (rgn < siqs_pkg::RGN_NCH) begin
      rd_word = {{6{iq_rd_a[rgn][19]}}, iq_rd_a[rgn][19:10],
                 {6{iq_rd_a[rgn][9]}}, iq_rd_a[rgn][9:0]}; // [R19]
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_VME_DATA <= 32'h00000000;
      O_VME_DATA_OE <= 1'b0;
      O_VME_DTACK_N <= 1'b1;
      O_VME_DTACK_OE <= 1'b0;
      O_ACCESS_INDICATOR <= 1'b0;
      O_MODIFIER_VALID_INDICATOR <= 1'b0;
    end else begin
      if (st_reg == siqs_pkg::ST_FETCH) begin
        O_VME_DATA <= beat_reg.lword ? rd_word
          : beat_reg.half ? {16'h0000, rd_word[15:0]}
          : {16'h0000, rd_word[31:16]}; // [R10]
      end
      O_VME_DATA_OE <= st_next == siqs_pkg::ST_ACK && !beat_reg.wr;
      O_VME_DTACK_N <= st_next != siqs_pkg::ST_ACK;
      O_VME_DTACK_OE <= st_next == siqs_pkg::ST_ACK;
      O_ACCESS_INDICATOR <= st_reg == siqs_pkg::ST_ACK && ds_none; // [R4]
      O_MODIFIER_VALID_INDICATOR <= as_low_reg && am_ok(am_reg); // [R4]
    end
  end

  siqs_mem #(.LANES(4), .LANE_W(8)) u_sweep_mem ( // [R10]
    .i_clk(I_CLK),
    .i_we(sweep_we),
    .i_addr_a(addr_reg[12:2]),
    .i_wdata(wdata_reg),
    .o_rdata_a(sweep_rd_a),
    .i_addr_b(sweep_rd_idx),
    .o_rdata_b(sweep_rd_b)
  );

  assign sweep_rd_idx = (I_SINGLE_FREQ || I_SWEEP_LEN == siqs_pkg::LEN_ZERO)
    ? siqs_pkg::IDX_IDLE : O_SWEEP_ADDR; // [R8]

  // sweep side: strobe stage 0 is read only by stage 1
  logic [2:0] strb_sync_reg;
  logic [4:0] gate_meta_reg, gate_reg;
  logic strobe_edge, pending_reg, inflight_reg, take, pop;
  logic sp_v_reg;
  logic [31:0] sp_w_reg;
  logic [1:0] fill;

  assign strobe_edge = strb_sync_reg[1] && !strb_sync_reg[2]; // [R23]
  assign fill = {1'b0, O_FREQ_VALID} + {1'b0, sp_v_reg}
              + {1'b0, inflight_reg};
  assign take = pending_reg && fill < 2'h2;
  assign pop = O_FREQ_VALID && I_FREQ_READY;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      strb_sync_reg <= 3'h0;
      gate_meta_reg <= 5'h00;
      gate_reg <= 5'h00;
    end else begin
      strb_sync_reg <= {strb_sync_reg[1:0], I_SWEEP_STEP_STROBE}; // [R23]
      gate_meta_reg <= I_CHAN_GATE;
      gate_reg <= gate_meta_reg; // [R23]
    end
  end

  // a new edge beats the clear; an edge while one is still pending merges into it
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pending_reg <= 1'b0;
      inflight_reg <= 1'b0;
    end else begin
      pending_reg <= strobe_edge || (pending_reg && !take);
      inflight_reg <= take; // [R9]
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_SWEEP_ADDR <= siqs_pkg::IDX_IDLE;
    end else if (I_SINGLE_FREQ || I_SWEEP_LEN == siqs_pkg::LEN_ZERO) begin
      O_SWEEP_ADDR <= siqs_pkg::IDX_IDLE; // [R8] [R13]
    end else if (I_SWEEP_ADDR_RESET) begin
      O_SWEEP_ADDR <= siqs_pkg::IDX_FIRST;
    end else if (take) begin
      O_SWEEP_ADDR <= step_ptr(O_SWEEP_ADDR, I_SWEEP_LEN,
        I_END_SWEEP_CTRL[siqs_pkg::ESC_SWEEP_BIT]); // [R9] [R12]
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_SWEEP_AT_IDLE <= 1'b1;
    end else begin
      O_SWEEP_AT_IDLE <= sweep_rd_idx == siqs_pkg::IDX_IDLE;
    end
  end

  // two-word skid buffer toward the synthesiser, head is the output
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_FREQ_VALID <= 1'b0;
      O_FREQ_WORD <= 32'h00000000;
      sp_v_reg <= 1'b0;
      sp_w_reg <= 32'h00000000;
    end else if (pop || !O_FREQ_VALID) begin
      if (sp_v_reg) begin
        O_FREQ_WORD <= sp_w_reg;
        O_FREQ_VALID <= 1'b1;
        sp_v_reg <= inflight_reg;
        sp_w_reg <= sweep_rd_b;
      end else begin
        O_FREQ_VALID <= inflight_reg; // [R5]
        O_FREQ_WORD <= sweep_rd_b;
      end
    end else if (inflight_reg) begin
      sp_v_reg <= 1'b1;
      sp_w_reg <= sweep_rd_b;
    end
  end

  // 20 MHz sample enable
  logic [3:0] smp_cnt_reg;
  logic smp_en;
  assign smp_en = smp_cnt_reg == siqs_pkg::SAMPLE_LAST;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || smp_en) begin
      smp_cnt_reg <= siqs_pkg::SAMPLE_ZERO;
    end else begin
      smp_cnt_reg <= smp_cnt_reg + 4'h1;
    end
  end

  logic [11:0] nc_cnt_reg [siqs_pkg::NCH];
  logic [19:0] iq_wdata;
  assign iq_wdata = {wdata_reg[25:16], wdata_reg[9:0]}; // [R14]

  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  for (genvar c = 0; c < siqs_pkg::NCH; c++) begin : g_ch
    logic [1:0] iq_we;
    assign iq_we = (st_reg == siqs_pkg::ST_SEL && beat_reg.wr
                    && rgn == 3'(c))
      ? {beat_reg.be[3] | beat_reg.be[2], beat_reg.be[1] | beat_reg.be[0]}
      : 2'h0;

    siqs_mem #(.LANES(2), .LANE_W(10)) u_iq_mem ( // [R7] [R14]
      .i_clk(I_CLK),
      .i_we(iq_we),
      .i_addr_a(addr_reg[12:2]),
      .i_wdata(iq_wdata),
      .o_rdata_a(iq_rd_a[c]),
      .i_addr_b(O_IQ_ADDR[c]),
      .o_rdata_b(iq_rd_b[c])
    );

    always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
        O_IQ_ADDR[c] <= siqs_pkg::IDX_IDLE;
        nc_cnt_reg[c] <= siqs_pkg::NC_ZERO;
      end else if (I_IQ_LEN[c] == siqs_pkg::LEN_ZERO) begin
        O_IQ_ADDR[c] <= siqs_pkg::IDX_IDLE; // [R17]
        nc_cnt_reg[c] <= siqs_pkg::NC_ZERO;
      end else if (!gate_reg[c]) begin
        O_IQ_ADDR[c] <= siqs_pkg::IDX_FIRST; // [R15]
        nc_cnt_reg[c] <= siqs_pkg::NC_ZERO;
      end else if (smp_en) begin
        // factor 0 behaves as 1: one step per sample
        if ({1'b0, nc_cnt_reg[c]} + 13'h0001
            >= {1'b0, I_BUFFER_FACTOR[c]}) begin // [R18] [R22]
          nc_cnt_reg[c] <= siqs_pkg::NC_ZERO;
          O_IQ_ADDR[c] <= step_ptr(O_IQ_ADDR[c], I_IQ_LEN[c],
                                   I_END_SWEEP_CTRL[c]); // [R16]
        end else begin
          nc_cnt_reg[c] <= nc_cnt_reg[c] + 12'h001;
        end
      end
    end

    always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
        O_IQ[c] <= '0;
      end else begin
        O_IQ[c] <= iq_rd_b[c]; // [R19]
      end
    end

    iq_len0_a: assert property (I_IQ_LEN[c] == siqs_pkg::LEN_ZERO // [R17]
      |=> O_IQ_ADDR[c] == siqs_pkg::IDX_IDLE)
      else $error("zero length did not park pointer on idle");
    gate_reset_a: assert property (!gate_reg[c] // [R15]
      && I_IQ_LEN[c] != 11'h000
      |=> O_IQ_ADDR[c] == siqs_pkg::IDX_FIRST)
      else $error("inactive gate did not rewind pointer");
    iq_pace_a: assert property ($changed(O_IQ_ADDR[c]) && gate_reg[c] // [R18]
      && $past(gate_reg[c]) && $past(I_IQ_LEN[c]) != 11'h000
      |-> $past(smp_en))
      else $error("pointer stepped off the sample enable");
  end

  // trip latch: the event wins over a clear in the same cycle
  logic trip_reg, trip_next;
  assign trip_next = I_POWER_TRIP_INPUT || (trip_reg && !I_TRIP_CLEAR);

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      trip_reg <= 1'b0;
      O_RF_ENABLE <= 1'b0;
      O_CHAN_RF_ENABLE <= 5'h00;
      O_MOD_ENABLE <= 5'h00;
    end else begin
      trip_reg <= trip_next; // [R20]
      O_RF_ENABLE <= !trip_next; // [R20]
      O_CHAN_RF_ENABLE <= gate_reg & {5{!trip_next}}; // [R21]
      O_MOD_ENABLE <= gate_reg & {5{I_QUAD_MODE}}; // [R5] [R21]
    end
  end
  assign O_TRIP_STATUS = trip_reg;

  sequence s_beat;
    st_reg == siqs_pkg::ST_SEL ##1 st_reg == siqs_pkg::ST_FETCH
      ##1 st_reg == siqs_pkg::ST_ACK && !O_VME_DTACK_N;
  endsequence

  am_filter_a: assert property (st_reg == siqs_pkg::ST_SEL // [R1]
    |-> am_ok(am_reg))
    else $error("cycle taken with a foreign modifier");
  base_match_a: assert property (st_reg == siqs_pkg::ST_SEL // [R2]
    |-> addr_reg[23:16] == {I_HIGH_NIBBLE_SWITCH, I_LOW_NIBBLE_SWITCH})
    else $error("cycle taken outside the switch range");
  beat_seq_a: assert property (st_reg == siqs_pkg::ST_SEL |-> s_beat) // [R3]
    else $error("beat did not acknowledge two cycles later");
  access_led_a: assert property (st_reg == siqs_pkg::ST_ACK && ds_none // [R4]
    |=> O_ACCESS_INDICATOR ##1 !O_ACCESS_INDICATOR)
    else $error("access indicator not pulsed once");
  sweep_len0_a: assert property (I_SWEEP_LEN == siqs_pkg::LEN_ZERO // [R13]
    |=> O_SWEEP_ADDR == siqs_pkg::IDX_IDLE)
    else $error("zero sweep length left the idle word");
  sweep_step_a: assert property (take && !I_SINGLE_FREQ // [R9]
    && !I_SWEEP_ADDR_RESET && I_SWEEP_LEN != 11'h000
    && O_SWEEP_ADDR < I_SWEEP_LEN - 11'h001
    |=> O_SWEEP_ADDR == $past(O_SWEEP_ADDR) + 11'h001)
    else $error("sweep pointer did not advance by one");
  strobe_once_a: assert property (strobe_edge // [R23]
    |=> !strobe_edge ##1 inflight_reg || pending_reg)
    else $error("strobe edge not acted on exactly once");
  trip_latch_a: assert property (I_POWER_TRIP_INPUT // [R20]
    |=> O_TRIP_STATUS && !O_RF_ENABLE)
    else $error("trip event did not cut the summed output");
endmodule : siqs_sequencer

// file: verilog/siqs_pkg.sv
package siqs_pkg;
  localparam int NCH = 5;
  localparam logic [10:0] IDX_IDLE = 11'h7ff;
  localparam logic [10:0] IDX_FIRST = 11'h000;
  localparam logic [10:0] LEN_ZERO = 11'h000;
  localparam logic [10:0] ONE_IDX = 11'h001;
  // accepted address modifiers, A24 only
  localparam logic [5:0] AM_USR_DATA = 6'h39;
  localparam logic [5:0] AM_USR_PROG = 6'h3a;
  localparam logic [5:0] AM_USR_BLT = 6'h3b;
  localparam logic [5:0] AM_SUP_DATA = 6'h3d;
  localparam logic [5:0] AM_SUP_PROG = 6'h3e;
  localparam logic [5:0] AM_SUP_BLT = 6'h3f;
  // byte offset bits 15:13 pick the region, 0..4 are modulation channels
  localparam logic [2:0] RGN_SWEEP = 3'h5;
  localparam logic [2:0] RGN_NCH = 3'h5;
  // next block beat, 4 bytes in units of address bit 1
  localparam logic [22:0] BLT_STEP = 23'h000002;
  localparam int ESC_SWEEP_BIT = 5;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SAMPLE_PERIOD_NS = 50;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS * 1000 / CLK_PERIOD_PS;
  localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_CYCLES - 1);
  localparam logic [3:0] SAMPLE_ZERO = 4'h0;
  localparam logic [11:0] NC_ZERO = 12'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEL = 2'h1,
    ST_FETCH = 2'h3,
    ST_ACK = 2'h2
  } siqs_state_e;

  typedef struct packed {
    logic signed [9:0] i;
    logic signed [9:0] q;
  } siqs_iq_s;

  typedef struct packed {
    logic [3:0] be;
    logic wr;
    logic lword;
    logic half;
  } siqs_beat_s;
endpackage : siqs_pkg

// file: verilog/siqs_mem.sv
`timescale 1ns/1ps
module siqs_mem #(
  parameter int LANES = 4,
  parameter int LANE_W = 8
) (
  input wire logic i_clk,
  input wire logic [LANES-1:0] i_we,
  input wire logic [10:0] i_addr_a,
  input wire logic [LANES*LANE_W-1:0] i_wdata,
  output logic [LANES*LANE_W-1:0] o_rdata_a,
  input wire logic [10:0] i_addr_b,
  output logic [LANES*LANE_W-1:0] o_rdata_b
);
  // contents survive reset on purpose
  logic [LANES*LANE_W-1:0] mem [0:2047];

  always_ff @(posedge i_clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (i_we[l]) begin
        mem[i_addr_a][l*LANE_W +: LANE_W] <= i_wdata[l*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata_a <= mem[i_addr_a];
    o_rdata_b <= mem[i_addr_b];
  end
endmodule : siqs_mem

// file: tb/siqs_vme_master.sv
`timescale 1ns/1ps
module siqs_vme_master (
  input wire logic i_clk,
  input wire logic i_dtack_n,
  input wire logic [31:0] i_rdata,
  output logic o_as_n,
  output logic [1:0] o_ds_n,
  output logic o_lword_n,
  output logic o_write_n,
  output logic [5:0] o_am,
  output logic [23:1] o_addr,
  output logic [31:0] o_wdata
);
  initial begin
    o_as_n = 1'b1;
    o_ds_n = 2'h3;
    o_lword_n = 1'b1;
    o_write_n = 1'b1;
    o_am = 6'h00;
    o_addr = 23'h000000;
    o_wdata = 32'h00000000;
  end

  // lag stretches address-to-strobe setup, as a slow master would
  task automatic xfer(input logic wr, input logic [5:0] am,
    input logic [23:0] a, input logic [1:0] ds, input logic lw,
    input logic [31:0] wd, input int lag, output logic [31:0] rd,
    output bit ok);
    ok = 0;
    rd = 32'h00000000;
    @(posedge i_clk);
    o_as_n <= 1'b0;
    o_am <= am;
    o_addr <= a[23:1];
    o_lword_n <= lw;
    o_write_n <= ~wr;
    o_wdata <= wd;
    repeat (lag + 1) @(posedge i_clk);
    o_ds_n <= ds;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge i_clk);
      if (i_dtack_n === 1'b0) begin
        ok = 1;
        rd = i_rdata;
      end
    end
    o_ds_n <= 2'h3;
    o_as_n <= 1'b1;
    // released lines must not keep looking valid
    o_wdata <= ~wd;
    for (int i = 0; i < 8 && i_dtack_n !== 1'b1; i++) @(posedge i_clk);
    @(posedge i_clk);
  endtask : xfer
endmodule : siqs_vme_master

// file: tb/siqs_sequencer_tb_top.sv
`timescale 1ns/1ps
module siqs_sequencer_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic as_n, lword_n, write_n;
  logic [1:0] ds_n;
  logic [5:0] am;
  logic [23:1] addr;
  logic [31:0] wdata, rdata, freq_word;
  logic data_oe, dtack_n, dtack_oe, access_ind, amv, freq_valid, at_idle;
  logic rf_en, trip_st;
  logic [10:0] sweep_addr;
  siqs_pkg::siqs_iq_s [4:0] iq;
  logic [4:0][10:0] iq_addr;
  logic [4:0] mod_en, chan_en;
  logic quad = 1'b0, single = 1'b0, srew = 1'b0, strb = 1'b0;
  logic trip = 1'b0, trip_clr = 1'b0, rdy = 1'b1;
  logic [5:0] esc = 6'h00;
  logic [10:0] slen = 11'h000;
  logic [4:0] gate = 5'h00;
  logic [4:0][10:0] iq_len = '0;
  logic [4:0][11:0] bf = '0;
  int n_errors = 0, n_compared = 0, n_access = 0, n_amv = 0, lag = 0;
  logic [31:0] got_q[$], exp_q[$];
  logic [5:0] ams [6] = '{siqs_pkg::AM_USR_DATA, siqs_pkg::AM_USR_PROG,
    siqs_pkg::AM_USR_BLT, siqs_pkg::AM_SUP_DATA, siqs_pkg::AM_SUP_PROG,
    siqs_pkg::AM_SUP_BLT};
  // lines are pulled up while nobody drives them
  wire dtack_w = dtack_oe ? dtack_n : 1'b1;
  wire [31:0] rdata_w = data_oe ? rdata : 32'hffffffff;

  always #2.5 clk = ~clk;

  siqs_sequencer siqs_sequencer_inst (.I_CLK(clk), .I_SYS_RST(rst),
    .I_VME_AS_N(as_n), .I_VME_DS_N(ds_n), .I_VME_LWORD_N(lword_n),
    .I_VME_WRITE_N(write_n), .I_VME_AM(am), .I_VME_ADDR(addr),
    .I_VME_DATA(wdata), .O_VME_DATA(rdata), .O_VME_DATA_OE(data_oe),
    .O_VME_DTACK_N(dtack_n), .O_VME_DTACK_OE(dtack_oe),
    .I_LOW_NIBBLE_SWITCH(4'h5), .I_HIGH_NIBBLE_SWITCH(4'ha),
    .O_ACCESS_INDICATOR(access_ind), .O_MODIFIER_VALID_INDICATOR(amv),
    .I_QUAD_MODE(quad), .I_SINGLE_FREQ(single), .I_END_SWEEP_CTRL(esc),
    .I_SWEEP_LEN(slen), .I_SWEEP_ADDR_RESET(srew),
    .I_SWEEP_STEP_STROBE(strb), .I_CHAN_GATE(gate), .I_IQ_LEN(iq_len),
    .I_BUFFER_FACTOR(bf), .I_POWER_TRIP_INPUT(trip),
    .I_TRIP_CLEAR(trip_clr), .O_FREQ_VALID(freq_valid),
    .O_FREQ_WORD(freq_word), .I_FREQ_READY(rdy),
    .O_SWEEP_ADDR(sweep_addr), .O_SWEEP_AT_IDLE(at_idle), .O_IQ(iq),
    .O_IQ_ADDR(iq_addr), .O_MOD_ENABLE(mod_en),
    .O_CHAN_RF_ENABLE(chan_en), .O_RF_ENABLE(rf_en),
    .O_TRIP_STATUS(trip_st));

  siqs_vme_master siqs_vme_master_inst (.i_clk(clk), .i_dtack_n(dtack_w),
    .i_rdata(rdata_w), .o_as_n(as_n), .o_ds_n(ds_n),
    .o_lword_n(lword_n), .o_write_n(write_n), .o_am(am), .o_addr(addr),
    .o_wdata(wdata));

  always @(posedge clk) begin
    if (access_ind === 1'b1) n_access++;
    if (amv === 1'b1) n_amv++;
    if (freq_valid === 1'b1 && rdy === 1'b1) got_q.push_back(freq_word);
  end

  function automatic logic [23:0] ad(input logic [15:0] off);
    ad = {8'ha5, off};
  endfunction : ad

  function automatic logic [31:0] sv(input int k);
    sv = 32'hc0de0000 + 32'(k);
  endfunction : sv

  task automatic chk32(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk32

  task automatic bus(input logic wr, input logic [5:0] a_m,
    input logic [23:0] a, input logic [1:0] ds, input logic lw,
    input logic [31:0] d, input bit eok, input logic [31:0] erd);
    logic [31:0] rd, msk;
    bit ok;
    int na, nm;
    na = n_access;
    nm = n_amv;
    msk = lw ? {16'h0, {8{~ds[1]}}, {8{~ds[0]}}} : 32'hffffffff;
    siqs_vme_master_inst.xfer(wr, a_m, a, ds, lw, d, lag, rd, ok);
    chk32("answered", 32'(eok), 32'(ok));
    chk32("access pulses", 32'(eok), 32'(n_access - na));
    chk32("am indicator", 32'(a_m inside {ams}), 32'(n_amv > nm));
    if (!wr && eok) begin
      chk32("read data", erd, rd & msk);
    end
  endtask : bus

  // st holds the stream stalled while the strobes arrive
  task automatic sweep(input logic [10:0] len, input logic e, input int n,
    input bit st);
    slen <= len;
    esc[5] <= e;
    srew <= 1'b1;
    rdy <= ~st;
    @(posedge clk);
    srew <= 1'b0;
    repeat (n) begin
      @(posedge clk);
      strb <= 1'b1;
      repeat (4) @(posedge clk);
      strb <= 1'b0;
      repeat (6) @(posedge clk);
    end
    repeat (20) @(posedge clk);
    rdy <= 1'b1;
    repeat (10) @(posedge clk);
    chk32("word count", exp_q.size(), got_q.size());
    foreach (exp_q[i]) begin
      if (i < got_q.size()) chk32("freq word", exp_q[i], got_q[i]);
    end
    got_q.delete();
  endtask : sweep

  task automatic step(input logic [10:0] ev, input int en);
    logic [10:0] p;
    int n;
    p = iq_addr[0];
    n = 0;
    while (iq_addr[0] === p && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk32("iq pointer", 32'(ev), 32'(iq_addr[0]));
    if (en > 0) chk32("step gap", en, n);
  endtask : step

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    tally_and_finish;
  end

  initial begin
    repeat (10) @(posedge clk);
    chk32("reset pointer", 32'h7ff, 32'(sweep_addr));
    rst <= 1'b0;
    foreach (ams[k]) bus(1, ams[k], ad(16'ha000 + 16'(4*k)), 0, 0, sv(k),
      1, 0);
    foreach (ams[k]) bus(0, ams[k], ad(16'ha000 + 16'(4*k)), 0, 0, 0, 1,
      sv(k));
    bus(0, 6'h3c, ad(16'ha000), 0, 0, 0, 0, 0);
    bus(0, 6'h09, ad(16'ha000), 0, 0, 0, 0, 0);
    bus(0, ams[3], 24'h5aa000, 0, 0, 0, 0, 0);
    lag = 3;
    bus(1, ams[0], ad(16'ha000), 0, 0, 32'h11223344, 1, 0);
    bus(0, ams[0], ad(16'ha000), 2'h1, 1, 0, 1, 32'h1100);
    bus(0, ams[0], ad(16'ha000), 2'h2, 1, 0, 1, 32'h22);
    bus(0, ams[0], ad(16'ha002), 2'h0, 1, 0, 1, 32'h3344);
    bus(1, ams[0], ad(16'ha002), 2'h2, 1, 32'h99, 1, 0);
    bus(0, ams[0], ad(16'ha000), 0, 0, 0, 1, 32'h11223399);
    lag = 0;
    bus(1, ams[0], ad(16'ha000), 0, 0, sv(0), 1, 0);
    bus(1, ams[0], ad(16'hbffc), 0, 0, sv(2047), 1, 0);
    $display("bus test done");
    exp_q = '{sv(0), sv(1), sv(2), sv(2047), sv(2047)};
    sweep(3, 1, 5, 0);
    exp_q = '{sv(0), sv(1), sv(2), sv(2)};
    sweep(3, 0, 4, 0);
    chk32("at idle", 0, 32'(at_idle));
    exp_q = '{sv(0), sv(1), sv(2)};
    sweep(3, 0, 3, 1);
    exp_q = '{sv(2047), sv(2047)};
    sweep(0, 1, 2, 0);
    chk32("sweep pointer", 32'h7ff, 32'(sweep_addr));
    chk32("at idle", 1, 32'(at_idle));
    single <= 1'b1;
    exp_q = '{sv(2047)};
    sweep(3, 1, 1, 0);
    single <= 1'b0;
    $display("sweep test done");
    bus(1, ams[0], ad(16'h0000), 0, 0, 32'h03fd0005, 1, 0);
    bus(1, ams[0], ad(16'h0004), 0, 0, 32'h00010001, 1, 0);
    bus(1, ams[0], ad(16'h0008), 0, 0, 32'h00020002, 1, 0);
    bus(1, ams[0], ad(16'h1ffc), 0, 0, 32'h00070007, 1, 0);
    bus(0, ams[0], ad(16'h0000), 0, 0, 0, 1, 32'hfffd0005);
    quad <= 1'b1;
    iq_len[0] <= 11'h003;
    bf[0] <= 12'h002;
    esc[0] <= 1'b1;
    gate[1] <= 1'b1;
    repeat (10) @(posedge clk);
    chk32("iq pointer", 0, 32'(iq_addr[0]));
    chk32("iq pair", 32'h000ff405, 32'(iq[0]));
    chk32("idle pointer", 32'h7ff, 32'(iq_addr[1]));
    gate[0] <= 1'b1;
    step(11'h001, 0);
    step(11'h002, 20);
    step(11'h7ff, 20);
    chk32("mod enable", 1, 32'(mod_en[0]));
    chk32("chan enable", 1, 32'(chan_en[0]));
    quad <= 1'b0;
    gate[0] <= 1'b0;
    repeat (8) @(posedge clk);
    chk32("mod enable", 0, 32'(mod_en[0]));
    chk32("iq pointer", 0, 32'(iq_addr[0]));
    $display("modulation test done");
    trip <= 1'b1;
    @(posedge clk);
    trip <= 1'b0;
    repeat (5) @(posedge clk);
    chk32("trip status", 1, 32'(trip_st));
    chk32("rf enable", 0, 32'(rf_en));
    trip_clr <= 1'b1;
    @(posedge clk);
    trip_clr <= 1'b0;
    repeat (3) @(posedge clk);
    chk32("trip status", 0, 32'(trip_st));
    chk32("rf enable", 1, 32'(rf_en));
    $display("trip test done");
    tally_and_finish;
  end
endmodule : siqs_sequencer_tb_top
